// ===== rtl/lsw_pkg.sv
// constants shared by the serial write link ends
`default_nettype none

package lsw_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 50;
  localparam int SHIFT_HALF_NS = 1000;
  localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int OSC_PERIOD_NS = 312500;
  localparam int OSC_HALF_CYC = OSC_PERIOD_NS / (2 * MCLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // word and panel geometry
  // ---------------------------------------------------------------
  localparam int ADDR_BITS = 8;
  localparam int SEG_BITS = 64;
  localparam int ROWS = 8;
  localparam int MAX_CHIPS = 4;
  localparam int PANEL_WIDTH = MAX_CHIPS * SEG_BITS;
  localparam int PHASES_PER_ROW = 4;

  // ---------------------------------------------------------------
  // address word fields
  // ---------------------------------------------------------------
  localparam int DUMMY_LSB_POS = 0;
  localparam int ROW_ADDR_LSB_POS = 1;
  localparam int ROW_ADDR_MSB_POS = 3;
  localparam int CS_LOW_POS = 4;
  localparam int CS_HIGH_POS = 5;

  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_SEG_LO = 8'h08;
  localparam logic [7:0] REG_SEG_HI = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_CLEAR_POS = 0;
  localparam int CTRL_BLANK_POS = 1;
  localparam int STATUS_BUSY_POS = 0;
  localparam logic CTRL_CLEAR_RST = 1'b1;
  localparam logic CTRL_BLANK_RST = 1'b1;

endpackage : lsw_pkg

`default_nettype wire

// ===== rtl/lsw_link_if.sv
// serial write link between host and display driver
`timescale 1ns/1ps
`default_nettype none

interface lsw_link_if;
  logic serial_data;
  logic shift_clk;
  logic latch;
  logic addr_sel;
  logic power_clear;
  logic display_blank;
  logic osc_clock_out;
  logic osc_clock_in;
  logic frame_sync_o;
  logic frame_sync_oe;
  logic frame_sync_ext;
  logic frame_sync;

  // pin level: own driver while enabled, otherwise the far chip
  assign frame_sync = frame_sync_oe ? frame_sync_o : frame_sync_ext;

  modport host (
    output serial_data,
    output shift_clk,
    output latch,
    output addr_sel,
    output power_clear,
    output display_blank
  );

  modport device (
    input serial_data,
    input shift_clk,
    input latch,
    input addr_sel,
    input power_clear,
    input display_blank,
    input osc_clock_in,
    input frame_sync,
    output osc_clock_out,
    output frame_sync_o,
    output frame_sync_oe
  );
endinterface : lsw_link_if

`default_nettype wire

// ===== rtl/lsw_sync.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none

module lsw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lsw_sync_st_t;

  lsw_sync_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule : lsw_sync

`default_nettype wire

// ===== rtl/lsw_device.sv
// display driver end: serial write port, display memory and chip linkage
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module lsw_device #(
  parameter int OSC_HALF = lsw_pkg::OSC_HALF_CYC,
  parameter int SEG_W = lsw_pkg::SEG_BITS,
  parameter int ROW_N = lsw_pkg::ROWS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // serial link
  lsw_link_if.device link,
  // chip select straps
  input wire logic chip_select_low_bit,
  input wire logic chip_select_high_bit,
  // display side
  output logic [SEG_W-1:0] seg_out,
  output logic [ROW_N-1:0] com_out,
  output logic master_mode,
  output logic row_loaded
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [SEG_W-1:0] shreg;
    logic [SEG_W-1:0] hold;
    logic [ROW_N-1:0][SEG_W-1:0] mem;
    logic [2:0] row;
    logic row_ok;
    logic sck_p;
    logic lat_p;
    logic osc_p;
    logic fs_p;
    logic [15:0] div;
    logic osc_o;
    logic [1:0] phase;
    logic [2:0] scan;
    logic fs_o;
    logic [SEG_W-1:0] seg;
    logic [ROW_N-1:0] com;
    logic master;
    logic [1:0] settle;
  } lsw_dev_st_t;

  lsw_dev_st_t st_q, st_d;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [9:0] pin_raw;
  logic [9:0] pin_s;

  assign pin_raw = {chip_select_high_bit, chip_select_low_bit, link.frame_sync,
                    link.osc_clock_in, link.display_blank, link.power_clear,
                    link.addr_sel, link.latch, link.serial_data, link.shift_clk};

  lsw_sync #(
    .W(10)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d(pin_raw),
    .q(pin_s)
  );

  logic s_sck, s_sdi, s_lat, s_asel, s_por, s_blank, s_osc, s_fs, s_cs0, s_cs1;

  assign s_sck = pin_s[0];
  assign s_sdi = pin_s[1];
  assign s_lat = pin_s[2];
  assign s_asel = pin_s[3];
  assign s_por = pin_s[4];
  assign s_blank = pin_s[5];
  assign s_osc = pin_s[6];
  assign s_fs = pin_s[7];
  assign s_cs0 = pin_s[8];
  assign s_cs1 = pin_s[9];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [lsw_pkg::ADDR_BITS-1:0] aword;
    logic tick;
    st_d = st_q;
    aword = '0;
    tick = 1'b0;

    st_d.sck_p = s_sck;
    st_d.lat_p = s_lat;
    st_d.osc_p = s_osc;
    st_d.fs_p = s_fs;

    // mode from straps, only once the synchroniser holds real levels,
    // so a slave never drives frame sync in the cycles after reset
    st_d.settle = (st_q.settle == 2'h3) ? 2'h3 : st_q.settle + 2'h1;
    st_d.master = (st_q.settle == 2'h3) && !s_cs0 && !s_cs1;

    // serial write port
    if (s_por) begin
      st_d.row_ok = 1'b0;
    end else begin
      if (s_sck && !st_q.sck_p) begin
        st_d.shreg = {st_q.shreg[SEG_W-2:0], s_sdi};
      end
      if (s_lat) begin
        st_d.hold = st_q.shreg;
      end
      if (!s_lat && st_q.lat_p) begin
        if (s_asel) begin
          for (int i = 0; i < lsw_pkg::ADDR_BITS; i++) begin
            aword[i] = st_q.hold[lsw_pkg::ADDR_BITS-1-i];
          end
          if (aword[lsw_pkg::CS_HIGH_POS] == s_cs1 &&
              aword[lsw_pkg::CS_LOW_POS] == s_cs0) begin
            st_d.row = aword[lsw_pkg::ROW_ADDR_MSB_POS:lsw_pkg::ROW_ADDR_LSB_POS];
            st_d.row_ok = 1'b1;
          end else begin
            st_d.row_ok = 1'b0;
          end
        end else if (st_q.row_ok) begin
          st_d.mem[st_q.row] = st_q.hold;
        end
      end
    end

    // master oscillator divider
    if (st_q.master) begin
      if (st_q.div == 16'(OSC_HALF - 1)) begin
        st_d.div = '0;
        st_d.osc_o = !st_q.osc_o;
        tick = !st_q.osc_o;
      end else begin
        st_d.div = st_q.div + 16'h0001;
      end
    end else begin
      st_d.div = '0;
      st_d.osc_o = 1'b0;
      tick = s_osc && !st_q.osc_p;
    end

    // row scan
    if (s_por) begin
      st_d.phase = '0;
      st_d.scan = '0;
    end else if (!st_q.master && (s_fs != st_q.fs_p)) begin
      st_d.phase = '0;
      st_d.scan = '0;
    end else if (tick) begin
      st_d.phase = st_q.phase + 2'h1;
      if (st_q.phase == 2'(lsw_pkg::PHASES_PER_ROW - 1)) begin
        st_d.scan = st_q.scan + 3'h1;
        if (st_q.scan == 3'(ROW_N - 1) && st_q.master) begin
          st_d.fs_o = !st_q.fs_o;
        end
      end
    end
    if (!st_q.master) begin
      st_d.fs_o = 1'b0;
    end

    // display outputs
    if (s_por) begin
      st_d.com = '0;
      st_d.seg = '0;
    end else begin
      st_d.com = ROW_N'(1) << st_q.scan;
      st_d.seg = s_blank ? '0 : st_q.mem[st_q.scan];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.osc_clock_out = st_q.osc_o;
  assign link.frame_sync_o = st_q.fs_o;
  assign link.frame_sync_oe = st_q.master;
  assign seg_out = st_q.seg;
  assign com_out = st_q.com;
  assign master_mode = st_q.master;
  assign row_loaded = st_q.row_ok;

endmodule : lsw_device

`default_nettype wire

// ===== rtl/lsw_host.sv
// host end: register port that shifts address and segment words out
`timescale 1ns/1ps
`default_nettype none

module lsw_host #(
  parameter int HALF = lsw_pkg::SHIFT_HALF_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // serial link
  lsw_link_if.host link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_LOW = 5'b00010,
    H_HIGH = 5'b00100,
    H_LATCH = 5'b01000,
    H_GAP = 5'b10000
  } lsw_hstate_t;

  typedef struct packed {
    lsw_hstate_t state;
    logic [15:0] cnt;
    logic [6:0] bitn;
    logic [6:0] last;
    logic [63:0] word;
    logic [31:0] seg_lo;
    logic por;
    logic blank;
    logic [31:0] rdata;
    logic sck;
    logic sdo;
    logic lat;
    logic asel;
  } lsw_host_st_t;

  lsw_host_st_t st_q, st_d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [63:0] full;
    logic half_done;
    st_d = st_q;
    full = '0;
    half_done = (st_q.cnt == 16'(HALF - 1));
    st_d.cnt = half_done ? '0 : st_q.cnt + 16'h0001;

    // register reads
    st_d.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        lsw_pkg::REG_CTRL: st_d.rdata = {30'h0, st_q.blank, st_q.por};
        lsw_pkg::REG_SEG_LO: st_d.rdata = st_q.seg_lo;
        lsw_pkg::REG_STATUS: st_d.rdata = {31'h0, st_q.state != H_IDLE};
        default: st_d.rdata = '0;
      endcase
    end

    // register writes
    if (reg_write) begin
      case (reg_addr)
        lsw_pkg::REG_CTRL: begin
          st_d.por = reg_wdata[lsw_pkg::CTRL_CLEAR_POS];
          st_d.blank = reg_wdata[lsw_pkg::CTRL_BLANK_POS];
        end
        lsw_pkg::REG_SEG_LO: st_d.seg_lo = reg_wdata;
        default: ;
      endcase
    end

    case (st_q.state)
      H_IDLE: begin
        st_d.cnt = '0;
        st_d.sck = 1'b0;
        st_d.lat = 1'b0;
        if (reg_write && reg_addr == lsw_pkg::REG_ADDR) begin
          st_d.word = {56'h0, reg_wdata[7:0]};
          st_d.sdo = reg_wdata[0];
          st_d.last = 7'(lsw_pkg::ADDR_BITS - 1);
          st_d.asel = 1'b1;
          st_d.bitn = '0;
          st_d.state = H_LOW;
        end else if (reg_write && reg_addr == lsw_pkg::REG_SEG_HI) begin
          full = {reg_wdata, st_q.seg_lo};
          for (int i = 0; i < 64; i++) begin
            st_d.word[i] = full[63-i];
          end
          st_d.sdo = full[63];
          st_d.last = 7'(lsw_pkg::SEG_BITS - 1);
          st_d.asel = 1'b0;
          st_d.bitn = '0;
          st_d.state = H_LOW;
        end
      end
      H_LOW: begin
        if (half_done) begin
          st_d.sck = 1'b1;
          st_d.state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          st_d.sck = 1'b0;
          if (st_q.bitn == st_q.last) begin
            st_d.lat = 1'b1;
            st_d.state = H_LATCH;
          end else begin
            st_d.bitn = st_q.bitn + 7'h01;
            st_d.word = {1'b0, st_q.word[63:1]};
            st_d.sdo = st_q.word[1];
            st_d.state = H_LOW;
          end
        end
      end
      H_LATCH: begin
        if (half_done) begin
          st_d.lat = 1'b0;
          st_d.state = H_GAP;
        end
      end
      H_GAP: begin
        if (half_done) begin
          st_d.state = H_IDLE;
        end
      end
      default: st_d.state = H_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{state: H_IDLE, por: lsw_pkg::CTRL_CLEAR_RST,
                blank: lsw_pkg::CTRL_BLANK_RST, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = st_q.rdata;
  assign link.serial_data = st_q.sdo;
  assign link.shift_clk = st_q.sck;
  assign link.latch = st_q.lat;
  assign link.addr_sel = st_q.asel;
  assign link.power_clear = st_q.por;
  assign link.display_blank = st_q.blank;

endmodule : lsw_host

`default_nettype wire

// ===== test/lsw_chk.sv
// assertions on the serial write link between host and display ends
`timescale 1ns/1ps
`default_nettype none

module lsw_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // link signals
  input wire logic serial_data,
  input wire logic shift_clk,
  input wire logic latch,
  input wire logic addr_sel,
  input wire logic osc_clock_out,
  input wire logic frame_sync_o,
  input wire logic frame_sync_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // ----
  // link checks
  // ----
  shift_high_a: assert property ($rose(shift_clk) |-> shift_clk [*4])
    else $error("shift clock high half too short");
  shift_low_a: assert property ($fell(shift_clk) |-> !shift_clk [*4])
    else $error("shift clock low half too short");
  data_setup_a: assert property ($rose(shift_clk) |-> $stable(serial_data))
    else $error("serial data moved at shift edge");
  latch_quiet_a: assert property (latch && $past(latch) |-> $stable(shift_clk))
    else $error("shift clock moved while latch open");
  latch_width_a: assert property ($rose(latch) |-> latch [*4] ##1 !latch)
    else $error("latch pulse width wrong");
  sel_hold_a: assert property (latch |-> $stable(addr_sel))
    else $error("word select moved during latch");
  osc_half_a: assert property ($rose(osc_clock_out) |-> osc_clock_out [*4] ##1 !osc_clock_out)
    else $error("oscillator half period wrong");
  slave_osc_a: assert property ($rose(osc_clock_out) |-> frame_sync_oe)
    else $error("oscillator driven outside master mode");
  frame_gap_a: assert property (frame_sync_oe && $changed(frame_sync_o) |=> $stable(frame_sync_o) [*8])
    else $error("frame sync toggled too soon");

  address_word_c: cover property ($fell(latch) && addr_sel);
  segment_word_c: cover property ($fell(latch) && !addr_sel);
  frame_turn_c: cover property (frame_sync_oe && $changed(frame_sync_o));
endmodule : lsw_chk

`default_nettype wire

// ===== test/lcd_serial_write_multichip_test.sv
// bench for host and display ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none

module lcd_serial_write_multichip_test;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic cs_lo = 1'b0;
  logic cs_hi = 1'b0;
  logic osc_run = 1'b0;
  logic [63:0] seg_out;
  logic [7:0] com_out;
  logic master_mode;
  logic row_loaded;
  logic [31:0] rd_q;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [63:0] WORD = 64'hF0E1_D2C3_B4A5_9687;

  lsw_link_if link ();

  lsw_host #(.HALF(4)) lsw_host_inst (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .link(link)
  );

  lsw_device #(.OSC_HALF(4)) lsw_device_inst (
    .mclk(mclk), .reset_n(reset_n), .link(link), .chip_select_low_bit(cs_lo),
    .chip_select_high_bit(cs_hi), .seg_out(seg_out), .com_out(com_out),
    .master_mode(master_mode), .row_loaded(row_loaded)
  );

  lsw_chk lsw_chk_inst (
    .mclk(mclk), .reset_n(reset_n), .serial_data(link.serial_data),
    .shift_clk(link.shift_clk), .latch(link.latch), .addr_sel(link.addr_sel),
    .osc_clock_out(link.osc_clock_out), .frame_sync_o(link.frame_sync_o),
    .frame_sync_oe(link.frame_sync_oe)
  );

  // ----
  // clocks and access tasks
  // ----
  initial begin
    forever #25 mclk = ~mclk;
  end

  // far master oscillator, free of the local clock phase
  initial begin
    link.osc_clock_in = 1'b0;
    #37;
    forever #200 link.osc_clock_in = osc_run & ~link.osc_clock_in;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("unexpected at %0t: run too long", $time);
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd

  task idle;
    for (int i = 0; i < 500; i++) begin
      rd(lsw_pkg::REG_STATUS);
      if (rd_q[0] === 1'b0) break;
    end
    repeat (8) @(posedge mclk);
    #1;
  endtask : idle

  task send_addr(input logic [7:0] a);
    wr(lsw_pkg::REG_ADDR, {24'h000000, a});
    idle();
  endtask : send_addr

  task send_seg(input logic [63:0] s);
    wr(lsw_pkg::REG_SEG_LO, s[31:0]);
    wr(lsw_pkg::REG_SEG_HI, s[63:32]);
    idle();
  endtask : send_seg

  task see_row(input int r);
    for (int i = 0; i < 2000 && com_out !== (8'h01 << r); i++) @(posedge mclk);
    repeat (6) @(posedge mclk);
    #1;
  endtask : see_row

  task restart;
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : restart

  // ----
  // test sequence
  // ----
  initial begin
    link.frame_sync_ext <= 1'b0;
    restart();
    rd(lsw_pkg::REG_CTRL);
    chk(64'(rd_q), 64'h3);
    chk({62'h0, master_mode, link.frame_sync_oe}, 64'h3);
    send_addr(8'h0B);
    chk(64'(row_loaded), 64'h0);
    chk(64'(com_out), 64'h0);
    wr(lsw_pkg::REG_CTRL, 32'h0);
    send_addr(8'hCB);
    chk(64'(row_loaded), 64'h1);
    send_seg(WORD);
    see_row(5);
    chk(seg_out, WORD);
    send_addr(8'h1B);
    chk(64'(row_loaded), 64'h0);
    send_seg(~WORD);
    see_row(5);
    chk(seg_out, WORD);
    send_addr(8'h0F);
    send_seg(~WORD);
    see_row(7);
    chk(seg_out, ~WORD);
    see_row(5);
    chk(seg_out, WORD);
    wr(lsw_pkg::REG_CTRL, 32'h2);
    see_row(7);
    chk(seg_out, 64'h0);
    rd(8'h20);
    chk(64'(rd_q), 64'h0);
    @(posedge mclk);
    cs_lo <= 1'b1;
    restart();
    osc_run <= 1'b1;
    wr(lsw_pkg::REG_CTRL, 32'h0);
    chk({62'h0, master_mode, link.frame_sync_oe}, 64'h0);
    send_addr(8'h13);
    chk(64'(row_loaded), 64'h1);
    send_seg(WORD);
    see_row(1);
    chk(seg_out, WORD);
    see_row(2);
    chk(64'(com_out), 64'h4);
    @(posedge mclk);
    link.frame_sync_ext <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(64'(com_out), 64'h1);
    close_out();
  end
endmodule : lcd_serial_write_multichip_test

`default_nettype wire
